/* File: design/fsmd_pkg.sv */
// constants, register map and descriptor field layout for the status-map decoder
package fsmd_pkg;

	// width of the flash-side 6-byte command-address
	localparam int CMD_ADDR_W = 48;
	// generic register command size code for 6 bytes; other codes unused
	localparam logic [1:0] CMD_SIZE_6BYTE = 2'h0;

	// apb register byte offsets
	localparam logic [7:0] ADDR_CTRL        = 8'h00;
	localparam logic [7:0] ADDR_ERR_DESC    = 8'h04;
	localparam logic [7:0] ADDR_VDUM_DESC   = 8'h08;
	localparam logic [7:0] ADDR_NVDUM_DESC  = 8'h0C;
	localparam logic [7:0] ADDR_STATUS      = 8'h10;
	localparam logic [7:0] ADDR_DUMMY       = 8'h14;
	localparam logic [7:0] ADDR_CMD_ADDR_LO = 8'h18;

	// erase-error descriptor fields
	localparam int EE_SUP_BIT   = 31;
	localparam int EE_POL_BIT   = 30;
	localparam int EE_BYTE1_BIT = 29;
	localparam int EE_SHARE_BIT = 28;
	localparam int EE_POS_MSB   = 27;
	localparam int EE_POS_LSB   = 24;
	localparam int EE_ADDR_MSB  = 23;
	localparam int EE_ADDR_LSB  = 16;
	localparam int EE_RSVD_MSB  = 15;

	// dummy-cycle descriptor fields, same layout for volatile and non-volatile
	localparam int DC_SUP_BIT   = 31;
	localparam int DC_RSVD_BIT  = 30;
	localparam int DC_BYTE1_BIT = 29;
	localparam int DC_W_MSB     = 28;
	localparam int DC_W_LSB     = 27;
	localparam int DC_POS_MSB   = 26;
	localparam int DC_POS_LSB   = 23;
	localparam int DC_ADDR_MSB  = 22;
	localparam int DC_ADDR_LSB  = 15;
	localparam int DC_RSVD_MSB  = 14;
	localparam logic [2:0] DC_MIN_WIDTH = 3'h2;

	// control register fields
	localparam int CTRL_OP_MSB  = 1;
	localparam int CTRL_OP_LSB  = 0;
	localparam int CTRL_NV_BIT  = 4;
	localparam int CTRL_VAL_MSB = 12;
	localparam int CTRL_VAL_LSB = 8;
	localparam logic [1:0] OP_NONE        = 2'h0;
	localparam logic [1:0] OP_ERASE_CHECK = 2'h1;
	localparam logic [1:0] OP_DUMMY_READ  = 2'h2;
	localparam logic [1:0] OP_DUMMY_WRITE = 2'h3;

	// status register bits
	localparam int ST_BUSY_BIT  = 0;
	localparam int ST_DONE_BIT  = 1;
	localparam int ST_UNSUP_BIT = 2;
	localparam int ST_EERR_BIT  = 3;
	localparam int ST_SHARE_BIT = 4;
	localparam int ST_RSVD_BIT  = 5;

	// reset values
	localparam logic [31:0] DESC_RESET  = 32'h0000_0000;
	localparam logic [4:0]  DUMMY_RESET = 5'h00;

endpackage : fsmd_pkg

/* File: design/fsmd_host.sv */
// host-side decoder of flash status/control map descriptors with apb control
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/10ps
module fsmd_host
	import fsmd_pkg::*;
#(
	parameter int DATA_W = 32
) (
	// clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  rst,
	// apb slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic                       pready,
	output logic                       pslverr,
	output logic [31:0]                prdata,
	// generic register access toward the flash controller
	output logic                       reg_req,
	output logic                       reg_write,
	output logic                       reg_nonvol,
	output logic [1:0]                 reg_addr_size,
	output logic [CMD_ADDR_W-1:0]      reg_cmd_addr,
	output logic [DATA_W-1:0]          reg_wdata,
	input  wire logic                  reg_ack,
	input  wire logic [DATA_W-1:0]     reg_rdata,
	// decoded status
	output logic                       erase_error,
	output logic                       busy
);

	typedef enum logic [1:0] {
		FSMD_IDLE,
		FSMD_READ,
		FSMD_WRITE
	} fsmd_state_e;

	typedef struct packed {
		fsmd_state_e           st;
		logic [31:0]           err_desc;
		logic [31:0]           vdum_desc;
		logic [31:0]           nvdum_desc;
		logic [1:0]            op;
		logic                  nv;
		logic [4:0]            dval;
		logic                  busy;
		logic                  done;
		logic                  unsup;
		logic                  eerr;
		logic                  shared;
		logic                  rsvd_err;
		logic [4:0]            dummy;
		logic                  req;
		logic                  wr;
		logic [CMD_ADDR_W-1:0] cmd_addr;
		logic [DATA_W-1:0]     wdata;
		logic [31:0]           prdata;
		logic                  slverr;
	} fsmd_state_s;

	fsmd_state_s state_reg;
	fsmd_state_s state_next;

	// local register address placed into the 48-bit command-address
	function automatic logic [CMD_ADDR_W-1:0] fsmd_cmd_addr(input logic byte1, input logic [7:0] addr);
		logic [CMD_ADDR_W-1:0] a;
		a = '0;
		if (byte1) begin
			a[15:8] = addr;
		end else begin
			a[7:0] = addr;
		end
		return a;
	endfunction : fsmd_cmd_addr

	// mask of the dummy field, already shifted to its position
	function automatic logic [DATA_W-1:0] fsmd_mask(input logic [1:0] wcode, input logic [3:0] pos);
		logic [2:0]        w;
		logic [DATA_W-1:0] m;
		w = DC_MIN_WIDTH + {1'b0, wcode};
		m = (DATA_W'(1) << w) - DATA_W'(1);
		return m << pos;
	endfunction : fsmd_mask

	logic              apb_setup;
	logic              apb_wr;
	logic              addr_ok;
	logic [31:0]       dsel_desc;
	logic [31:0]       next_dsel_desc;
	logic [3:0]        dpos;
	logic [DATA_W-1:0] dmask;
	logic [DATA_W-1:0] dfield;
	logic [1:0]        start_op;
	logic              start_nv;

	assign apb_setup = psel & ~penable;
	assign apb_wr    = psel & penable & pwrite;
	assign addr_ok   = (paddr == ADDR_CTRL) || (paddr == ADDR_ERR_DESC) || (paddr == ADDR_VDUM_DESC) ||
	                   (paddr == ADDR_NVDUM_DESC) || (paddr == ADDR_STATUS) || (paddr == ADDR_DUMMY) ||
	                   (paddr == ADDR_CMD_ADDR_LO);

	// field geometry of the descriptor of the operation in flight
	assign dsel_desc = state_reg.nv ? state_reg.nvdum_desc : state_reg.vdum_desc;
	assign dpos      = dsel_desc[DC_POS_MSB:DC_POS_LSB];
	assign dmask     = fsmd_mask(dsel_desc[DC_W_MSB:DC_W_LSB], dpos);
	assign dfield    = (reg_rdata & dmask) >> dpos;

	assign start_op       = pwdata[CTRL_OP_MSB:CTRL_OP_LSB];
	assign start_nv       = pwdata[CTRL_NV_BIT];
	assign next_dsel_desc = start_nv ? state_reg.nvdum_desc : state_reg.vdum_desc;

	always_comb begin
		state_next = state_reg;

		// read data is fetched in the setup cycle so it leaves a flip-flop
		if (apb_setup) begin
			state_next.slverr = ~addr_ok;
			case (paddr)
				ADDR_ERR_DESC:    state_next.prdata = state_reg.err_desc;
				ADDR_VDUM_DESC:   state_next.prdata = state_reg.vdum_desc;
				ADDR_NVDUM_DESC:  state_next.prdata = state_reg.nvdum_desc;
				ADDR_STATUS:      state_next.prdata = {26'h0, state_reg.rsvd_err, state_reg.shared, state_reg.eerr,
				                                       state_reg.unsup, state_reg.done, state_reg.busy};
				ADDR_DUMMY:       state_next.prdata = {27'h0, state_reg.dummy};
				ADDR_CMD_ADDR_LO: state_next.prdata = state_reg.cmd_addr[31:0];
				ADDR_CTRL:        state_next.prdata = {19'h0, state_reg.dval, 3'h0, state_reg.nv, 2'h0, state_reg.op};
				default:          state_next.prdata = 32'h0000_0000;
			endcase
		end

		// done is cleared by writing one; a completion in the same cycle wins below
		if (apb_wr && paddr == ADDR_STATUS && pwdata[ST_DONE_BIT]) begin
			state_next.done = 1'b0;
		end

		// descriptors are frozen while an access is in flight
		if (apb_wr && state_reg.st == FSMD_IDLE) begin
			case (paddr)
				ADDR_ERR_DESC:   state_next.err_desc   = pwdata;
				ADDR_VDUM_DESC:  state_next.vdum_desc  = pwdata;
				ADDR_NVDUM_DESC: state_next.nvdum_desc = pwdata;
				default:         state_next.err_desc   = state_reg.err_desc;
			endcase
		end

		case (state_reg.st)
			FSMD_IDLE: begin
				// a start while busy is ignored because only idle reaches here
				if (apb_wr && paddr == ADDR_CTRL && start_op != OP_NONE) begin
					state_next.op    = start_op;
					state_next.nv    = start_nv;
					state_next.dval  = pwdata[CTRL_VAL_MSB:CTRL_VAL_LSB];
					state_next.unsup = 1'b0;
					state_next.wr    = 1'b0;
					if (start_op == OP_ERASE_CHECK) begin
						state_next.shared   = state_reg.err_desc[EE_SHARE_BIT];
						state_next.rsvd_err = state_reg.err_desc[EE_RSVD_MSB:0] != 16'h0000;
						if (!state_reg.err_desc[EE_SUP_BIT]) begin
							state_next.unsup = 1'b1;
							state_next.eerr  = 1'b0;
							state_next.done  = 1'b1;
						end else begin
							state_next.cmd_addr = fsmd_cmd_addr(state_reg.err_desc[EE_BYTE1_BIT],
							                                    state_reg.err_desc[EE_ADDR_MSB:EE_ADDR_LSB]);
							state_next.req  = 1'b1;
							state_next.busy = 1'b1;
							state_next.st   = FSMD_READ;
						end
					end else begin
						state_next.rsvd_err = next_dsel_desc[DC_RSVD_BIT] ||
						                      next_dsel_desc[DC_RSVD_MSB:0] != 15'h0000;
						if (!next_dsel_desc[DC_SUP_BIT]) begin
							state_next.unsup = 1'b1;
							state_next.done  = 1'b1;
						end else begin
							state_next.cmd_addr = fsmd_cmd_addr(next_dsel_desc[DC_BYTE1_BIT],
							                                    next_dsel_desc[DC_ADDR_MSB:DC_ADDR_LSB]);
							state_next.req  = 1'b1;
							state_next.busy = 1'b1;
							state_next.st   = FSMD_READ;
						end
					end
				end
			end
			FSMD_READ: begin
				if (reg_ack) begin
					state_next.req = 1'b0;
					case (state_reg.op)
						OP_ERASE_CHECK: begin
							// normalise to active high whatever the device polarity
							state_next.eerr = reg_rdata[state_reg.err_desc[EE_POS_MSB:EE_POS_LSB]] ^
							                  state_reg.err_desc[EE_POL_BIT];
							state_next.busy = 1'b0;
							state_next.done = 1'b1;
							state_next.st   = FSMD_IDLE;
						end
						OP_DUMMY_READ: begin
							state_next.dummy = dfield[4:0];
							state_next.busy  = 1'b0;
							state_next.done  = 1'b1;
							state_next.st    = FSMD_IDLE;
						end
						default: begin
							// read-modify-write keeps the other bits of the setting register
							state_next.wdata = (reg_rdata & ~dmask) | ((DATA_W'(state_reg.dval) << dpos) & dmask);
							state_next.req   = 1'b1;
							state_next.wr    = 1'b1;
							state_next.st    = FSMD_WRITE;
						end
					endcase
				end
			end
			FSMD_WRITE: begin
				if (reg_ack) begin
					state_next.req   = 1'b0;
					state_next.wr    = 1'b0;
					state_next.dummy = state_reg.dval & dfield_width_mask(dsel_desc[DC_W_MSB:DC_W_LSB]);
					state_next.busy  = 1'b0;
					state_next.done  = 1'b1;
					state_next.st    = FSMD_IDLE;
				end
			end
			default: begin
				state_next.st  = FSMD_IDLE;
				state_next.req = 1'b0;
			end
		endcase
	end

	// unshifted mask of the value bits that fit the field
	function automatic logic [4:0] dfield_width_mask(input logic [1:0] wcode);
		case (wcode)
			2'h0:    return 5'h03;
			2'h1:    return 5'h07;
			2'h2:    return 5'h0F;
			default: return 5'h1F;
		endcase
	endfunction : dfield_width_mask

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_reg.st         <= FSMD_IDLE;
			state_reg.err_desc   <= DESC_RESET;
			state_reg.vdum_desc  <= DESC_RESET;
			state_reg.nvdum_desc <= DESC_RESET;
			state_reg.op         <= OP_NONE;
			state_reg.nv         <= 1'b0;
			state_reg.dval       <= DUMMY_RESET;
			state_reg.busy       <= 1'b0;
			state_reg.done       <= 1'b0;
			state_reg.unsup      <= 1'b0;
			state_reg.eerr       <= 1'b0;
			state_reg.shared     <= 1'b0;
			state_reg.rsvd_err   <= 1'b0;
			state_reg.dummy      <= DUMMY_RESET;
			state_reg.req        <= 1'b0;
			state_reg.wr         <= 1'b0;
			state_reg.cmd_addr   <= '0;
			state_reg.wdata      <= '0;
			state_reg.prdata     <= 32'h0000_0000;
			state_reg.slverr     <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	// zero-wait slave: every access phase completes in its first cycle
	assign pready        = 1'b1;
	assign pslverr       = psel & penable & state_reg.slverr;
	assign prdata        = state_reg.prdata;
	assign reg_req       = state_reg.req;
	assign reg_write     = state_reg.wr;
	assign reg_nonvol    = state_reg.nv & (state_reg.op != OP_ERASE_CHECK);
	assign reg_addr_size = CMD_SIZE_6BYTE;
	assign reg_cmd_addr  = state_reg.cmd_addr;
	assign reg_wdata     = state_reg.wdata;
	assign erase_error   = state_reg.eerr;
	assign busy          = state_reg.busy;

endmodule : fsmd_host

/* File: verif/fsmd_flash_model.sv */
// behavioural flash answering generic register reads and writes
`timescale 1ns/10ps
module fsmd_flash_model
	import fsmd_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// generic register access
	input  wire logic        reg_req,
	input  wire logic        reg_write,
	input  wire logic [1:0]  reg_addr_size,
	input  wire logic [47:0] reg_cmd_addr,
	input  wire logic [31:0] reg_wdata,
	output logic             reg_ack,
	output logic [31:0]      reg_rdata
);
	logic [31:0] mem [256];
	logic [7:0]  loc;
	int          wait_cnt = 0;

	// the unused byte is zero, so either placement lands here
	assign loc = reg_cmd_addr[7:0] | reg_cmd_addr[15:8];
	initial begin
		reg_ack   = 1'b0;
		reg_rdata = 32'h0000_0000;
	end
	always @(posedge clk_sys) begin
		reg_ack <= 1'b0;
		// released data toggles so a stale word never passes for an answer
		reg_rdata <= ~reg_rdata;
		if (!rst && reg_req && !reg_ack && reg_addr_size == CMD_SIZE_6BYTE) begin
			if (wait_cnt == 0) begin
				reg_ack   <= 1'b1;
				reg_rdata <= mem[loc];
				if (reg_write)
					mem[loc] <= reg_wdata;
				wait_cnt <= $urandom_range(3, 0);
			end else
				wait_cnt <= wait_cnt - 1;
		end
	end
endmodule : fsmd_flash_model

/* File: verif/fsmd_host_assertions.sv */
// port assertions for the status-map decoder
`timescale 1ns/10ps
module fsmd_host_assertions
	import fsmd_pkg::*;
(
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        rst,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] prdata,
	// flash side and status
	input wire logic        reg_req,
	input wire logic        reg_write,
	input wire logic [1:0]  reg_addr_size,
	input wire logic [47:0] reg_cmd_addr,
	input wire logic        reg_ack,
	input wire logic        erase_error,
	input wire logic        busy
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_apb_no_wait: assert property (psel && penable |-> pready) else $error("pready low");
	a_size_six_byte: assert property (reg_req |-> reg_addr_size == CMD_SIZE_6BYTE)
		else $error("size code");
	a_addr_one_byte: assert property (reg_req |-> reg_cmd_addr[47:16] == '0 &&
		(reg_cmd_addr[15:8] == '0 || reg_cmd_addr[7:0] == '0)) else $error("cmd address");
	a_req_holds: assert property (reg_req && !reg_ack |=> reg_req && $stable(reg_cmd_addr) && $stable(reg_write))
		else $error("request dropped");
	a_req_by_start: assert property ($rose(reg_req) |-> $past(psel && penable && pwrite && paddr == ADDR_CTRL))
		else $error("request without start");
	a_write_ends: assert property (reg_req && reg_ack && reg_write |=> !reg_req && !busy) else $error("no end");
	a_busy_req: assert property (reg_req |-> busy) else $error("busy low");
	// an unsupported check clears the flag at its start write, with no flash access
	a_err_on_ack: assert property ($changed(erase_error) |->
		$past((reg_req && reg_ack && !reg_write) || (psel && penable && pwrite && paddr == ADDR_CTRL)))
		else $error("erase flag moved");
	a_unmapped_err: assert property (psel && !penable && paddr > ADDR_CMD_ADDR_LO ##1 penable
		|-> pslverr && prdata == '0) else $error("unmapped");
	a_slverr_access: assert property (pslverr |-> psel && penable) else $error("stray pslverr");

	c_read_ack: cover property (reg_req && reg_ack && !reg_write);
	c_write_ack: cover property (reg_req && reg_ack && reg_write);
	c_slverr: cover property (pslverr);
endmodule : fsmd_host_assertions

bind fsmd_host fsmd_host_assertions i_chk (
	.clk_sys       (clk_sys),
	.rst           (rst),
	.psel          (psel),
	.penable       (penable),
	.pwrite        (pwrite),
	.paddr         (paddr),
	.pready        (pready),
	.pslverr       (pslverr),
	.prdata        (prdata),
	.reg_req       (reg_req),
	.reg_write     (reg_write),
	.reg_addr_size (reg_addr_size),
	.reg_cmd_addr  (reg_cmd_addr),
	.reg_ack       (reg_ack),
	.erase_error   (erase_error),
	.busy          (busy)
);

/* File: verif/tb.sv */
// self-checking bench for the status-map decoder
`timescale 1ns/10ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin mismatches++; \
	$display("mismatch %s expected %h seen %h", n, e, a); end end
module tb
	import fsmd_pkg::*;
;
	logic        clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, reg_wdata, reg_rdata;
	logic        pready, pslverr, reg_req, reg_write, reg_nonvol, reg_ack, erase_error, busy;
	logic [1:0]  reg_addr_size;
	logic [47:0] reg_cmd_addr;
	logic [64:0] exp_q[$];
	int          mismatches = 0, check_count = 0;
	logic        exp_nv = 1'b0;

	always #10 clk_sys = ~clk_sys;
	fsmd_host i_dut (.*);
	fsmd_flash_model i_flash (.*);

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : apb

	// note is {pslverr, compare mask, data}
	task automatic rd(input logic [7:0] a, input logic [64:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask : rd

	task automatic run_op(input logic [31:0] ctrl);
		apb(1'b1, ADDR_CTRL, ctrl);
		while (busy !== 1'b0) @(posedge clk_sys);
	endtask : run_op

	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run

	always @(posedge clk_sys) begin : monitor
		logic [64:0] e;
		if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			`CHK("apb read", {e[64], e[31:0]}, {pslverr, prdata & e[63:32]})
		end
		if (reg_req && reg_ack)
			`CHK("reg_nonvol", exp_nv, reg_nonvol)
	end

	initial begin : watchdog
		repeat (20000) @(posedge clk_sys);
		mismatches++;
		complete_run();
	end

	initial begin : main
		logic [31:0] r, d, m;
		logic [7:0]  a;
		logic [3:0]  pos;
		logic [4:0]  v;
		logic        pol, b1, sh, ee, nv;
		void'($urandom(67526));
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		// all registers clear, 0x1C unmapped
		for (int k = 0; k <= 7; k++)
			rd(8'(k * 4), {k == 7, 32'hFFFF_FFFF, DESC_RESET});
		for (int i = 0; i < 8; i++) begin
			{sh, b1, pol} = 3'(i);
			pos = 4'($urandom);
			a = 8'($urandom);
			r = $urandom;
			ee = r[pos] ^ pol;
			i_flash.mem[a] = r;
			d = {1'b1, pol, b1, sh, pos, a, 16'h0000};
			apb(1'b1, ADDR_ERR_DESC, d);
			// nv set on purpose: an erase check must never target the non-volatile side
			run_op(32'h0000_0011);
			`CHK("erase_error", ee, erase_error)
			rd(ADDR_STATUS, {1'b0, 32'hFFFF_FFFF, 26'h0, 1'b0, sh, ee, 3'b010});
			rd(ADDR_CMD_ADDR_LO, {1'b0, 32'hFFFF_FFFF, 16'h0, b1 ? {a, 8'h00} : {8'h00, a}});
		end
		apb(1'b1, ADDR_ERR_DESC, 32'h7FFF_0000);
		run_op(32'h0000_0001);
		rd(ADDR_STATUS, {1'b0, 32'h0000_0007, 32'h0000_0006});
		apb(1'b1, ADDR_STATUS, 32'h0000_0002);
		rd(ADDR_STATUS, {1'b0, 32'h0000_0002, 32'h0000_0000});
		apb(1'b1, ADDR_VDUM_DESC, 32'h4000_0001);
		run_op(32'h0000_0002);
		rd(ADDR_STATUS, {1'b0, 32'h0000_0027, 32'h0000_0026});
		for (int j = 0; j < 8; j++) begin
			nv = j[0];
			exp_nv = nv;
			b1 = 1'($urandom);
			pos = 4'($urandom);
			a = 8'($urandom);
			r = $urandom;
			v = 5'($urandom);
			m = (32'h1 << (j[2:1] + 2)) - 1;
			i_flash.mem[a] = r;
			d = {1'b1, 1'b0, b1, 2'(j >> 1), pos, a, 15'h0000};
			// the other word is unsupported so a wrong pick shows
			apb(1'b1, nv ? ADDR_VDUM_DESC : ADDR_NVDUM_DESC, 32'h0000_0000);
			apb(1'b1, nv ? ADDR_NVDUM_DESC : ADDR_VDUM_DESC, d);
			run_op({19'h0, 5'h00, 3'h0, nv, 4'h2});
			rd(ADDR_DUMMY, {1'b0, 32'hFFFF_FFFF, (r >> pos) & m});
			run_op({19'h0, v, 3'h0, nv, 4'h3});
			rd(ADDR_DUMMY, {1'b0, 32'hFFFF_FFFF, 32'(v) & m});
			`CHK("flash reg", (r & ~(m << pos)) | ((32'(v) & m) << pos), i_flash.mem[a])
			rd(ADDR_CMD_ADDR_LO, {1'b0, 32'hFFFF_FFFF, 16'h0, b1 ? {a, 8'h00} : {8'h00, a}});
		end
		complete_run();
	end
endmodule : tb
